// ---- src/rsa_pkg.sv ----
package rsa_pkg;
  localparam int RSSI_W = 8;
  localparam int FREQ_W = 16;
  localparam int BR_W = 16;
  localparam int FIFO_W = 1;
  localparam int FIFO_D = 8;
  localparam logic [7:0] PEAK_DROP = 8'h0c;
  localparam int CLK_HZ = 10000000;
  localparam int TEMP_LIMIT_US = 100;
  localparam int TEMP_CYCLES = TEMP_LIMIT_US * (CLK_HZ / 1000000);
  localparam logic [15:0] TEMP_DONE_CNT = 16'(TEMP_CYCLES - 1);
  localparam int FEI_BITS = 4;
  localparam int TO_MULT_SH = 4;
  localparam logic [15:0] LOW_INDEX_STEP = 16'h0008;
  localparam logic [1:0] SLICE_FIXED = 2'h0;
  localparam logic [1:0] SLICE_PEAK = 2'h1;
  localparam logic [1:0] SLICE_AVG = 2'h2;
  localparam logic [2:0] MODE_STBY = 3'h1;
  localparam logic [2:0] MODE_FS = 3'h2;
  localparam logic [2:0] MODE_RX = 3'h4;
  localparam logic [FREQ_W-1:0] CARRIER_RST = 16'h0000;
  typedef enum logic [2:0] {
    AFC_IDLE = 3'b001,
    AFC_MEAS = 3'b010,
    AFC_APPLY = 3'b100
  } rsa_afc_t;
endpackage

// ---- src/rsa_fifo.sv ----
`timescale 1ns/1ps
module rsa_fifo #(
  parameter int W = 1,
  parameter int D = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic do_wr, do_rd;
  assign in_ready = cnt_reg != (AW+1)'(D);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_reg <= AW'((32'(wr_reg) + 1) % D);
      end
      if (do_rd) begin
        rd_reg <= AW'((32'(rd_reg) + 1) % D);
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ---- src/rsa_rx_assist.sv ----
`timescale 1ns/1ps
module rsa_rx_assist (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // mode
  input wire logic [2:0] op_mode,
  input wire logic packet_mode,
  input wire logic sync_disable,
  // demodulator
  input wire logic [7:0] rssi_level,
  input wire logic [1:0] ook_slicer_select,
  input wire logic [7:0] ook_floor_level,
  input wire logic [7:0] ook_decay_step,
  input wire logic [7:0] ook_decay_period,
  input wire logic [7:0] bitrate_high_byte,
  input wire logic [7:0] bitrate_low_byte,
  // recovered stream
  output logic recovered_clock_pin,
  output logic rec_valid,
  input wire logic rec_ready,
  output logic rec_data,
  output logic rec_overflow,
  // frequency correction
  input wire logic [15:0] freq_error_sample,
  input wire logic fei_start,
  input wire logic auto_correction_enable,
  input wire logic correction_start_bit,
  input wire logic correction_auto_clear,
  input wire logic low_index_correction_enable,
  input wire logic [7:0] low_index_offset,
  input wire logic [15:0] carrier_load,
  input wire logic carrier_load_en,
  output logic [15:0] freq_error_result,
  output logic [15:0] freq_correction_value,
  output logic [15:0] carrier_word,
  output logic fei_busy,
  output logic alt_bw_select,
  // temperature
  input wire logic temp_start_bit,
  input wire logic [7:0] adc_sample,
  output logic temp_running_flag,
  output logic [7:0] temp_result,
  output logic rx_blocks_off,
  // timeouts
  input wire logic [7:0] rx_start_timeout_count,
  input wire logic [7:0] post_detect_timeout_count,
  output logic signal_detect_flag,
  output logic timeout_irq
);
  logic in_rx, rx_prev_reg, rx_entry;
  logic [15:0] br_div, bit_cnt_reg;
  logic bit_tick;
  assign in_rx = op_mode == rsa_pkg::MODE_RX;
  assign rx_entry = in_rx && !rx_prev_reg;
  assign br_div = {bitrate_high_byte, bitrate_low_byte};
  assign bit_tick = in_rx && bit_cnt_reg == '0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end else begin
      rx_prev_reg <= in_rx;
      // free bit-period divider; reloaded at zero and on receive entry, data edges do not resync it
      if (rx_entry || bit_cnt_reg == '0) begin
        bit_cnt_reg <= br_div;
      end else begin
        bit_cnt_reg <= bit_cnt_reg - 16'h0001;
      end
    end
  end

  // slicer
  logic [7:0] peak_reg, avg_reg, dec_cnt_reg, thresh, peak_thr;
  logic raw_bit;
  assign peak_thr = (peak_reg > rsa_pkg::PEAK_DROP) ?
    peak_reg - rsa_pkg::PEAK_DROP : 8'h00;
  always_comb begin
    unique case (ook_slicer_select)
      rsa_pkg::SLICE_PEAK: thresh = (peak_thr > ook_floor_level) ?
        peak_thr : ook_floor_level;
      rsa_pkg::SLICE_AVG: thresh = avg_reg;
      default: thresh = ook_floor_level;
    endcase
  end
  assign raw_bit = rssi_level > thresh;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_reg <= '0;
      dec_cnt_reg <= '0;
      avg_reg <= '0;
    end else begin
      // 1/8 leaky average; only unbiased for DC-free coding
      avg_reg <= 8'((11'(avg_reg) * 7 + 11'(rssi_level)) >> 3);
      if (rssi_level >= peak_reg) begin
        peak_reg <= rssi_level;
        dec_cnt_reg <= '0;
      end else if (dec_cnt_reg >= ook_decay_period) begin
        dec_cnt_reg <= '0;
        // nine bits so a high floor plus step cannot wrap
        peak_reg <= (9'(peak_reg) >
          9'(ook_floor_level) + 9'(ook_decay_step)) ?
          peak_reg - ook_decay_step : ook_floor_level;
      end else begin
        dec_cnt_reg <= dec_cnt_reg + 8'h01;
      end
    end
  end

  // bit synchronizer: phase reset on data edge, sample mid-bit
  logic last_bit_reg, sync_on, mid_tick, fifo_ready;
  logic [15:0] phase_reg;
  assign sync_on = packet_mode || !sync_disable;
  assign mid_tick = in_rx && phase_reg == {1'b0, br_div[15:1]};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_bit_reg <= 1'b0;
      phase_reg <= '0;
      recovered_clock_pin <= 1'b0;
      rec_data <= 1'b0;
      rec_overflow <= 1'b0;
    end else begin
      last_bit_reg <= raw_bit;
      // edge resync tolerates rate mismatch of a few percent
      if (raw_bit != last_bit_reg || phase_reg >= br_div) begin
        phase_reg <= '0;
      end else begin
        phase_reg <= phase_reg + 16'h0001;
      end
      if (!sync_on) begin
        recovered_clock_pin <= 1'b0;
        rec_data <= raw_bit;
      end else if (mid_tick) begin
        recovered_clock_pin <= 1'b1;
        rec_data <= raw_bit;
        rec_overflow <= rec_overflow | !fifo_ready;
      end else if (phase_reg == '0) begin
        recovered_clock_pin <= 1'b0;
      end
    end
  end
  rsa_fifo #(.W(rsa_pkg::FIFO_W), .D(rsa_pkg::FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(sync_on && mid_tick),
    .in_ready(fifo_ready),
    .in_data(raw_bit),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data()
  );

  // frequency error and correction
  rsa_pkg::rsa_afc_t afc_reg;
  logic [2:0] fei_bits_reg;
  logic is_afc_reg;
  logic signed [19:0] acc_reg;
  logic [15:0] new_corr;
  assign fei_busy = afc_reg != rsa_pkg::AFC_IDLE;
  assign alt_bw_select = fei_busy && is_afc_reg;
  assign new_corr = freq_error_result + (low_index_correction_enable ?
    16'(low_index_offset * rsa_pkg::LOW_INDEX_STEP) : 16'h0000);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      afc_reg <= rsa_pkg::AFC_IDLE;
      fei_bits_reg <= '0;
      is_afc_reg <= 1'b0;
      acc_reg <= '0;
      freq_error_result <= '0;
      freq_correction_value <= '0;
      carrier_word <= rsa_pkg::CARRIER_RST;
    end else begin
      unique case (afc_reg)
        rsa_pkg::AFC_IDLE: begin
          if (carrier_load_en) begin
            carrier_word <= carrier_load;
          end
          // measurement validity relies on preamble at launch
          if ((auto_correction_enable && rx_entry) ||
              (!auto_correction_enable && correction_start_bit &&
               in_rx)) begin
            afc_reg <= rsa_pkg::AFC_MEAS;
            is_afc_reg <= 1'b1;
            fei_bits_reg <= '0;
            acc_reg <= '0;
            if (auto_correction_enable && correction_auto_clear) begin
              carrier_word <= carrier_word + freq_correction_value;
              freq_correction_value <= '0;
            end
          end else if (fei_start && in_rx) begin
            afc_reg <= rsa_pkg::AFC_MEAS;
            is_afc_reg <= 1'b0;
            fei_bits_reg <= '0;
            acc_reg <= '0;
          end
        end
        rsa_pkg::AFC_MEAS: begin
          if (bit_tick) begin
            acc_reg <= acc_reg + 20'(signed'(freq_error_sample));
            fei_bits_reg <= fei_bits_reg + 3'h1;
            if (fei_bits_reg == 3'(rsa_pkg::FEI_BITS - 1)) begin
              afc_reg <= rsa_pkg::AFC_APPLY;
            end
          end
        end
        rsa_pkg::AFC_APPLY: begin
          freq_error_result <= 16'(acc_reg >>> 2);
          afc_reg <= rsa_pkg::AFC_IDLE;
        end
        default: afc_reg <= rsa_pkg::AFC_IDLE;
      endcase
      if (afc_reg == rsa_pkg::AFC_IDLE && is_afc_reg &&
          fei_bits_reg == 3'(rsa_pkg::FEI_BITS)) begin
        freq_correction_value <= new_corr;
        carrier_word <= carrier_word - new_corr;
        fei_bits_reg <= '0;
      end
    end
  end

  // temperature
  logic [15:0] temp_cnt_reg;
  assign rx_blocks_off = temp_running_flag;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_running_flag <= 1'b0;
      temp_cnt_reg <= '0;
      temp_result <= '0;
    end else if (!temp_running_flag) begin
      if (temp_start_bit && (op_mode == rsa_pkg::MODE_STBY ||
          op_mode == rsa_pkg::MODE_FS)) begin
        temp_running_flag <= 1'b1;
        temp_cnt_reg <= '0;
      end
    end else if (temp_cnt_reg == rsa_pkg::TEMP_DONE_CNT) begin
      temp_running_flag <= 1'b0;
      temp_result <= ~adc_sample;
    end else begin
      temp_cnt_reg <= temp_cnt_reg + 16'h0001;
    end
  end

  // timeouts
  logic [11:0] to_cnt_reg;
  logic detect_seen_reg, timed_out_reg;
  assign signal_detect_flag = in_rx && raw_bit;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_reg <= '0;
      detect_seen_reg <= 1'b0;
      timed_out_reg <= 1'b0;
      timeout_irq <= 1'b0;
    end else begin
      timeout_irq <= 1'b0;
      if (rx_entry || !in_rx) begin
        to_cnt_reg <= '0;
        detect_seen_reg <= 1'b0;
        timed_out_reg <= 1'b0;
      end else if (!detect_seen_reg && signal_detect_flag) begin
        detect_seen_reg <= 1'b1;
        to_cnt_reg <= '0;
        timed_out_reg <= 1'b0;
      end else if (bit_tick && !timed_out_reg) begin
        to_cnt_reg <= to_cnt_reg + 12'h001;
        if (!detect_seen_reg && rx_start_timeout_count != '0 &&
            to_cnt_reg + 12'h001 ==
            {rx_start_timeout_count, 4'h0}) begin
          timeout_irq <= 1'b1;
          timed_out_reg <= 1'b1;
        end
        if (detect_seen_reg && post_detect_timeout_count != '0 &&
            to_cnt_reg + 12'h001 ==
            {post_detect_timeout_count, 4'h0}) begin
          timeout_irq <= 1'b1;
          timed_out_reg <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- sim/rsa_rx_assist_props.sv ----
`timescale 1ns/1ps
module rsa_rx_assist_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // mode and temperature
  input wire logic [2:0] op_mode,
  input wire logic temp_start_bit,
  input wire logic temp_running_flag,
  input wire logic rx_blocks_off,
  // correction, stream, timeouts
  input wire logic fei_busy,
  input wire logic alt_bw_select,
  input wire logic signal_detect_flag,
  input wire logic timeout_irq,
  input wire logic rec_overflow
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence temp_go;
    $rose(temp_running_flag);
  endsequence
  sequence temp_end;
    ##[1:1000] !temp_running_flag;
  endsequence
  temp_done_a: assert property (temp_go |-> temp_end)
    else $error("temperature run too long");
  temp_refuse_a: assert property (temp_start_bit && !temp_running_flag &&
    op_mode == rsa_pkg::MODE_RX |=> !temp_running_flag)
    else $error("temperature started in receive");
  temp_mode_a: assert property ($rose(temp_running_flag) |->
    $past(op_mode) == rsa_pkg::MODE_STBY ||
    $past(op_mode) == rsa_pkg::MODE_FS)
    else $error("temperature started outside standby or synth");
  blocks_off_a: assert property (rx_blocks_off == temp_running_flag)
    else $error("receive blocks not off during temperature");
  alt_bw_a: assert property (alt_bw_select |-> fei_busy)
    else $error("alternate bandwidth outside correction");
  fei_bound_a: assert property ($rose(fei_busy) |-> ##[1:1000] !fei_busy)
    else $error("measurement did not end");
  detect_rx_a: assert property (signal_detect_flag |->
    op_mode == rsa_pkg::MODE_RX)
    else $error("detect flag outside receive");
  irq_pulse_a: assert property (timeout_irq |=> !timeout_irq)
    else $error("timeout pulse too long");
  overflow_hold_a: assert property (rec_overflow |=> rec_overflow)
    else $error("overflow flag dropped");
endmodule
bind rsa_rx_assist rsa_rx_assist_props u_rsa_rx_assist_props (
  .core_clk(core_clk), .rst_n(rst_n), .op_mode(op_mode),
  .temp_start_bit(temp_start_bit), .temp_running_flag(temp_running_flag),
  .rx_blocks_off(rx_blocks_off), .fei_busy(fei_busy),
  .alt_bw_select(alt_bw_select), .signal_detect_flag(signal_detect_flag),
  .timeout_irq(timeout_irq), .rec_overflow(rec_overflow));

// ---- sim/rsa_tx_model.sv ----
`timescale 1ns/1ps
module rsa_tx_model #(
  parameter int PERIOD = 16
) (
  // clock
  input wire logic core_clk,
  // control
  input wire logic tx_en,
  input wire logic [7:0] mark_level,
  // signal strength seen by the receiver
  output logic [7:0] rssi_level
);
  int cnt = 0;
  logic bit_q = 1'b0;
  // same period as the receiver, so the sampler never slips a bit
  always @(posedge core_clk) begin
    if (!tx_en) begin
      cnt <= 0;
      bit_q <= 1'b0;
    end else if (cnt == PERIOD - 1) begin
      cnt <= 0;
      bit_q <= ~bit_q;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // no carrier sits well under the floor, not at the last level
  // mark level is free so the bench can place it against the slicing level
  assign rssi_level = (tx_en && bit_q) ? mark_level : 8'h10;
endmodule

// ---- sim/rsa_rx_assist_tb.sv ----
`timescale 1ns/1ps
module rsa_rx_assist_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, tx_en = 1'b0;
  logic [2:0] op_mode = rsa_pkg::MODE_STBY;
  logic packet_mode = 1'b0, rec_ready = 1'b1, temp_start_bit = 1'b0;
  logic sync_disable = 1'b0, fei_start = 1'b0;
  logic auto_correction_enable = 1'b0, correction_start_bit = 1'b0;
  logic correction_auto_clear = 1'b0, low_index_correction_enable = 1'b0;
  logic carrier_load_en = 1'b0;
  logic [1:0] ook_slicer_select = rsa_pkg::SLICE_FIXED;
  logic [7:0] low_index_offset = 8'h00, adc_sample = 8'h00;
  logic [7:0] rx_start_timeout_count = 8'h00;
  logic [7:0] post_detect_timeout_count = 8'h00, mark_level = 8'hc0;
  logic [15:0] freq_error_sample = 16'h0000, carrier_load = 16'h0000;
  logic [7:0] rssi_level, temp_result;
  logic [15:0] freq_error_result, freq_correction_value, carrier_word;
  logic recovered_clock_pin, rec_valid, rec_data, rec_overflow, fei_busy;
  logic alt_bw_select, temp_running_flag, rx_blocks_off;
  logic signal_detect_flag, timeout_irq;
  int miscompares = 0, comparisons = 0, cycles = 0;
  rsa_tx_model #(.PERIOD(16)) u_rsa_tx_model (.core_clk(core_clk),
    .tx_en(tx_en), .mark_level(mark_level), .rssi_level(rssi_level));
  rsa_rx_assist u_rsa_rx_assist (.core_clk(core_clk), .rst_n(rst_n),
    .op_mode(op_mode), .packet_mode(packet_mode),
    .sync_disable(sync_disable),
    .rssi_level(rssi_level), .ook_slicer_select(ook_slicer_select),
    .ook_floor_level(8'h80), .ook_decay_step(8'h01),
    .ook_decay_period(8'h01), .bitrate_high_byte(8'h00),
    .bitrate_low_byte(8'h0f), .recovered_clock_pin(recovered_clock_pin),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data),
    .rec_overflow(rec_overflow), .freq_error_sample(freq_error_sample),
    .fei_start(fei_start), .auto_correction_enable(auto_correction_enable),
    .correction_start_bit(correction_start_bit),
    .correction_auto_clear(correction_auto_clear),
    .low_index_correction_enable(low_index_correction_enable),
    .low_index_offset(low_index_offset), .carrier_load(carrier_load),
    .carrier_load_en(carrier_load_en),
    .freq_error_result(freq_error_result),
    .freq_correction_value(freq_correction_value),
    .carrier_word(carrier_word), .fei_busy(fei_busy),
    .alt_bw_select(alt_bw_select), .temp_start_bit(temp_start_bit),
    .adc_sample(adc_sample), .temp_running_flag(temp_running_flag),
    .temp_result(temp_result), .rx_blocks_off(rx_blocks_off),
    .rx_start_timeout_count(rx_start_timeout_count),
    .post_detect_timeout_count(post_detect_timeout_count),
    .signal_detect_flag(signal_detect_flag), .timeout_irq(timeout_irq));
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk(s, v, "handshake");
  endtask
  // manual starts are a one-cycle level so idle does not relaunch
  task automatic rx_entry(input logic man);
    tx_en = 1'b1;
    op_mode = rsa_pkg::MODE_STBY;
    repeat (2) @(negedge core_clk);
    op_mode = rsa_pkg::MODE_RX;
    correction_start_bit = man;
    @(negedge core_clk);
    correction_start_bit = 1'b0;
    wait_lvl(fei_busy, 1'b1);
    chk(alt_bw_select, 1'b1, "alt bandwidth");
    wait_lvl(fei_busy, 1'b0);
    repeat (3) @(negedge core_clk);
    tx_en = 1'b0;
  endtask
  task automatic count_detect(output int hits);
    hits = 0;
    repeat (40) begin
      @(negedge core_clk);
      if (signal_detect_flag === 1'b1) hits++;
    end
  endtask
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    int n;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    for (int i = 0; i < 2; i++) begin
      adc_sample = 8'h3c + 8'(i);
      temp_start_bit = 1'b1;
      @(negedge core_clk);
      temp_start_bit = 1'b0;
      wait_lvl(temp_running_flag, 1'b1);
      chk(rx_blocks_off, 1'b1, "blocks off");
      wait_lvl(temp_running_flag, 1'b0);
      chk(temp_result, 8'hc3 - 8'(i), "temperature");
    end
    carrier_load = 16'h1000;
    carrier_load_en = 1'b1;
    @(negedge core_clk);
    carrier_load_en = 1'b0;
    chk(carrier_word, 16'h1000, "carrier load");
    freq_error_sample = 16'hfff0;
    rx_entry(1'b1);
    chk(freq_error_result, 16'hfff0, "error result");
    chk(carrier_word, 16'h1010, "manual carrier");
    temp_start_bit = 1'b1;
    repeat (3) @(negedge core_clk);
    temp_start_bit = 1'b0;
    chk(temp_running_flag, 1'b0, "temp in receive");
    auto_correction_enable = 1'b1;
    low_index_correction_enable = 1'b1;
    low_index_offset = 8'h02;
    freq_error_sample = 16'h0004;
    rx_entry(1'b0);
    chk(freq_correction_value, 16'h0014, "low index value");
    chk(carrier_word, 16'h0ffc, "low index carrier");
    low_index_correction_enable = 1'b0;
    correction_auto_clear = 1'b1;
    rx_entry(1'b0);
    chk(carrier_word, 16'h100c, "auto clear");
    auto_correction_enable = 1'b0;
    freq_error_sample = 16'h0008;
    tx_en = 1'b1;
    fei_start = 1'b1;
    @(negedge core_clk);
    fei_start = 1'b0;
    wait_lvl(fei_busy, 1'b1);
    chk(alt_bw_select, 1'b0, "plain measure bandwidth");
    wait_lvl(fei_busy, 1'b0);
    repeat (3) @(negedge core_clk);
    tx_en = 1'b0;
    chk(freq_error_result, 16'h0008, "plain measure");
    chk(carrier_word, 16'h100c, "carrier untouched");
    rx_start_timeout_count = 8'h01;
    // second entry must restart the count from zero
    for (int j = 0; j < 2; j++) begin
      op_mode = rsa_pkg::MODE_STBY;
      @(negedge core_clk);
      op_mode = rsa_pkg::MODE_RX;
      n = 0;
      while (timeout_irq !== 1'b1 && n < 400) begin
        @(negedge core_clk);
        n++;
      end
      chk(16'(n >= 240 && n <= 290), 16'h0001, "timeout");
    end
    rx_start_timeout_count = 8'h00;
    post_detect_timeout_count = 8'h01;
    op_mode = rsa_pkg::MODE_STBY;
    tx_en = 1'b1;
    @(negedge core_clk);
    op_mode = rsa_pkg::MODE_RX;
    n = 0;
    while (timeout_irq !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(n >= 240 && n <= 290), 16'h0001, "post timeout");
    post_detect_timeout_count = 8'h00;
    // weak mark: above the floor, below the held peak less the drop
    ook_slicer_select = rsa_pkg::SLICE_PEAK;
    repeat (40) @(negedge core_clk);
    mark_level = 8'h90;
    count_detect(n);
    chk(16'(n), 16'h0000, "peak slicer");
    ook_slicer_select = rsa_pkg::SLICE_FIXED;
    count_detect(n);
    chk(16'(n != 0), 16'h0001, "fixed slicer");
    mark_level = 8'h60;
    count_detect(n);
    chk(16'(n), 16'h0000, "fixed below floor");
    ook_slicer_select = rsa_pkg::SLICE_AVG;
    count_detect(n);
    chk(16'(n != 0), 16'h0001, "average slicer");
    ook_slicer_select = rsa_pkg::SLICE_FIXED;
    mark_level = 8'hc0;
    packet_mode = 1'b1;
    repeat (40) @(negedge core_clk);
    wait_lvl(recovered_clock_pin, 1'b0);
    wait_lvl(recovered_clock_pin, 1'b1);
    chk(rec_data, 16'(rssi_level > 8'h80), "sampled bit");
    chk(signal_detect_flag, 16'(rssi_level > 8'h80), "detect");
    chk(rec_overflow, 1'b0, "overflow while drained");
    sync_disable = 1'b1;
    wait_lvl(recovered_clock_pin, 1'b0);
    wait_lvl(recovered_clock_pin, 1'b1);
    rec_ready = 1'b0;
    wait_lvl(rec_overflow, 1'b1);
    tx_en = 1'b0;
    rec_ready = 1'b1;
    n = 0;
    while (rec_valid === 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    // a bit may land while draining, so one extra word is allowed
    chk(16'(n >= 8 && n <= 9), 16'h0001, "buffer depth");
    packet_mode = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(rec_data, 16'h0000, "plain data low");
    tx_en = 1'b1;
    wait_lvl(rec_data, 1'b1);
    chk(recovered_clock_pin, 1'b0, "clock disabled");
    tx_en = 1'b0;
    close_out();
  end
endmodule
